// ---- common/sign_branch_regs.vh ----
/*
 * Constants for the sign-test branch decoder: instruction field positions,
 * selector codes, register numbers and address steps.
 * Assumes 32-bit instruction words and 32-bit byte addresses.
 */
`ifndef SIGN_BRANCH_REGS_VH
`define SIGN_BRANCH_REGS_VH

// instruction fields
`define OPC_MSB          31
`define OPC_LSB          26
`define TST_MSB          25
`define TST_LSB          21
`define SEL_MSB          20
`define SEL_LSB          16
`define OFF_MSB          15
`define OFF_LSB          0

// major opcode of the register-immediate class
`define OPC_REG_IMM      6'h01

// selector codes
`define SEL_PLAIN        5'h01
`define SEL_LIKELY       5'h03
`define SEL_LINK         5'h11
`define SEL_LINK_LIKELY  5'h13

// register numbers
`define LINK_REG         5'h1f
`define ZERO_REG         5'h00

// address arithmetic
`define SLOT_STEP        32'h0000_0004
`define LINK_STEP        32'h0000_0008
`define OFF_SHIFT        2
`define OFF_EXT_BITS     14

// state codes
`define ST_IDLE          1'b0
`define ST_WAIT_SLOT     1'b1

`endif

// ---- dv/sign_test_branch_decode_asserts.sv ----
/* checker: port relations of the sign-test branch decoder.
   assumes one clock ref_clk and async active-low rstn. */
`timescale 1ns/1ps
`default_nettype none
module sign_test_branch_decode_asserts #(
    parameter DATA_W = 32 // register width
) (
    input wire logic              ref_clk,         // clock
    input wire logic              rstn,            // reset
    input wire logic              inst_valid,      // fetch valid
    input wire logic [31:0]       inst_word,       // word
    input wire logic [31:0]       inst_pc,         // address
    input wire logic [DATA_W-1:0] tested_value,    // tested reg
    input wire logic              slot_flush,      // abandon
    input wire logic              branch_hit_q,    // hit
    input wire logic              is_likely_q,     // likely
    input wire logic              is_link_q,       // link
    input wire logic              cond_q,          // condition
    input wire logic              link_we_q,       // link write
    input wire logic [4:0]        link_addr_q,     // link reg
    input wire logic [31:0]       link_data_q,     // link value
    input wire logic              wait_slot_q,     // pending
    input wire logic              slot_run_q,      // slot runs
    input wire logic              slot_kill_q,     // slot killed
    input wire logic              resolve_q,       // resolved
    input wire logic              resolve_taken_q, // taken
    input wire logic [31:0]       resolve_pc_q,    // next pc
    input wire logic              fault_q          // fault
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire idle_op = inst_valid && !wait_slot_q && !slot_flush && inst_word[31:26] == 6'h01;
    wire [4:0] sel = inst_word[20:16];
    property p_dec_plain; idle_op && (sel == 5'h01 || sel == 5'h03)
        |=> branch_hit_q && !is_link_q && !link_we_q; endproperty
    a_dec_plain: assert property (p_dec_plain) else $error("plain branch missed");
    property p_dec_link; idle_op && (sel == 5'h11 || sel == 5'h13)
        |=> branch_hit_q && is_link_q && link_we_q; endproperty
    a_dec_link: assert property (p_dec_link) else $error("link branch missed");
    property p_link_val; link_we_q
        |-> link_addr_q == 5'h1f && link_data_q == $past(inst_pc) + 32'h0000_0008; endproperty
    a_link_val: assert property (p_link_val) else $error("bad link write");
    property p_cond; branch_hit_q && $past(inst_word[25:21]) != 5'h00
        |-> cond_q == !$past(tested_value[DATA_W-1]); endproperty
    a_cond: assert property (p_cond) else $error("bad condition");
    property p_zero; branch_hit_q && $past(inst_word[25:21]) == 5'h00 |-> cond_q; endproperty
    a_zero: assert property (p_zero) else $error("zero reg not taken");
    property p_order; resolve_q |-> $past(wait_slot_q) && !wait_slot_q && !branch_hit_q;
    endproperty
    a_order: assert property (p_order) else $error("resolve out of order");
    property p_pair; wait_slot_q && inst_valid |=> !wait_slot_q; endproperty
    a_pair: assert property (p_pair) else $error("slot not paired");
    property p_kill; resolve_q |-> slot_kill_q == (is_likely_q && !cond_q)
        && slot_run_q == !slot_kill_q; endproperty
    a_kill: assert property (p_kill) else $error("bad slot kill");
    property p_taken; resolve_q |-> resolve_taken_q == cond_q; endproperty
    a_taken: assert property (p_taken) else $error("bad taken flag");
    property p_fault; !fault_q; endproperty
    a_fault: assert property (p_fault) else $error("fault raised");
endmodule // sign_test_branch_decode_asserts
bind sign_test_branch_decode sign_test_branch_decode_asserts #(.DATA_W(DATA_W)) chk_i (
    .ref_clk, .rstn, .inst_valid, .inst_word, .inst_pc, .tested_value, .slot_flush,
    .branch_hit_q, .is_likely_q, .is_link_q, .cond_q, .link_we_q, .link_addr_q,
    .link_data_q, .wait_slot_q, .slot_run_q, .slot_kill_q, .resolve_q,
    .resolve_taken_q, .resolve_pc_q, .fault_q);
`default_nettype wire

// ---- dv/sign_test_branch_decode_test.sv ----
/* bench for the sign-test branch decoder: branch table, then ignored
   words, slot abandon and reset. assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module sign_test_branch_decode_test;
    // tk and nx: expected taken flag and next fetch address after the slot
    typedef struct {logic [4:0] sel, rs; logic [15:0] off; logic [31:0] pc, val; logic tk;
        logic [31:0] nx;} row_t;
    logic        ref_clk = 0, rstn = 0, inst_valid = 0, slot_flush = 0;
    logic [31:0] inst_word = 0, inst_pc = 0, tested_value = 0;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    wire logic   branch_hit_q, is_likely_q, is_link_q, cond_q, link_we_q, wait_slot_q;
    wire logic   slot_run_q, slot_kill_q, resolve_q, resolve_taken_q, fault_q;
    wire logic [4:0]  link_addr_q;
    wire logic [31:0] link_data_q, resolve_pc_q;
    row_t rows [10] = '{
        '{5'h01, 5'h04, 16'h0010, 32'h0000_1000, 32'h0000_0000, 1'b1, 32'h0000_1044},
        '{5'h01, 5'h04, 16'hfffc, 32'h0000_2000, 32'h8000_0000, 1'b0, 32'h0000_2008},
        '{5'h03, 5'h05, 16'h7fff, 32'h0000_3000, 32'h7fff_ffff, 1'b1, 32'h0002_3000},
        '{5'h03, 5'h05, 16'h8000, 32'h0002_4000, 32'hffff_ffff, 1'b0, 32'h0002_4008},
        '{5'h11, 5'h06, 16'hffff, 32'h0000_5000, 32'h0000_0001, 1'b1, 32'h0000_5000},
        '{5'h11, 5'h06, 16'h0001, 32'h0000_6000, 32'h8000_0001, 1'b0, 32'h0000_6008},
        '{5'h13, 5'h07, 16'h0002, 32'h0000_7000, 32'h1234_5678, 1'b1, 32'h0000_700c},
        '{5'h13, 5'h07, 16'h0003, 32'h0000_8000, 32'hfedc_ba98, 1'b0, 32'h0000_8008},
        '{5'h11, 5'h00, 16'h0020, 32'h0000_9000, 32'hffff_ffff, 1'b1, 32'h0000_9084},
        '{5'h13, 5'h00, 16'h0004, 32'hffff_fff0, 32'h8000_0000, 1'b1, 32'h0000_0004}};
    sign_test_branch_decode #(.DATA_W(32)) sign_test_branch_decode_i (
        .ref_clk, .rstn, .inst_valid, .inst_word, .inst_pc, .tested_value, .slot_flush,
        .branch_hit_q, .is_likely_q, .is_link_q, .cond_q, .link_we_q, .link_addr_q,
        .link_data_q, .wait_slot_q, .slot_run_q, .slot_kill_q, .resolve_q,
        .resolve_taken_q, .resolve_pc_q, .fault_q);
    always #2.5 ref_clk = ~ref_clk;
    task give_verdict;
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // branch then its slot, leaving inst_valid high for the next row
    task run(input row_t r);
        logic c;
        c = r.tk;
        inst_valid = 1;
        inst_word = {6'h01, r.rs, r.sel, r.off};
        inst_pc = r.pc;
        tested_value = r.val;
        @(negedge ref_clk);
        chk(branch_hit_q, 1);
        chk(link_we_q, r.sel[4]);
        if (r.sel[4]) chk(link_data_q, r.pc + 32'h0000_0008);
        chk(cond_q, c);
        chk(wait_slot_q, 1);
        chk(is_likely_q, r.sel[1]);
        chk(is_link_q, r.sel[4]);
        inst_word = 32'h0000_0000;
        inst_pc = r.pc + 32'h0000_0004;
        tested_value = ~r.val;
        @(negedge ref_clk);
        chk(resolve_q, 1);
        chk(resolve_pc_q, r.nx);
        chk(fault_q, 0);
        chk(resolve_taken_q, c);
        chk(slot_kill_q, r.sel[1] && !c);
        chk(slot_run_q, !(r.sel[1] && !c));
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        chk(link_addr_q, 5'h1f);
        chk(wait_slot_q, 0);
        rstn = 1;
        foreach (rows[i]) run(rows[i]);
        inst_word = 32'h0410_0000;
        @(negedge ref_clk);
        chk(branch_hit_q, 0);
        inst_word = 32'h1c01_0000;
        @(negedge ref_clk);
        chk(branch_hit_q, 0);
        chk(wait_slot_q, 0);
        inst_word = {6'h01, 5'h00, 5'h01, 16'h0008};
        @(negedge ref_clk);
        chk(wait_slot_q, 1);
        slot_flush = 1;
        @(negedge ref_clk);
        chk(resolve_q, 0);
        chk(slot_run_q, 0);
        chk(slot_kill_q, 0);
        chk(wait_slot_q, 0);
        slot_flush = 0;
        @(negedge ref_clk);
        // same word taken again: a branch is pending when reset hits
        chk(wait_slot_q, 1);
        rstn = 0;
        inst_valid = 0;
        #1;
        chk(wait_slot_q, 0);
        chk(link_addr_q, 5'h1f);
        @(negedge ref_clk);
        rstn = 1;
        run(rows[4]);
        inst_valid = 0;
        @(negedge ref_clk);
        give_verdict;
    end
endmodule // sign_test_branch_decode_test
`default_nettype wire

// ---- rtl/branch_target_calc.v ----
/*
 * Address arithmetic for the sign-test branches: delay-slot address,
 * PC-relative target and return link, from the branch's own address.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sign_branch_regs.vh"

module branch_target_calc (
    input  wire [31:0] branch_pc,    // address of the branch itself
    input  wire [15:0] offset,       // word offset field
    output wire [31:0] slot_pc,      // address of the delay slot
    output wire [31:0] target_pc,    // taken destination
    output wire [31:0] link_pc       // return link, second after branch
);

    wire [31:0] byte_offset;

    // shift by two then sign-extend the 18-bit value
    assign byte_offset = {{`OFF_EXT_BITS{offset[15]}}, offset, {`OFF_SHIFT{1'b0}}}; // RL3
    assign slot_pc     = branch_pc + `SLOT_STEP;
    assign target_pc   = slot_pc + byte_offset;   // RL3
    assign link_pc     = branch_pc + `LINK_STEP;  // RL7

endmodule // branch_target_calc

`default_nettype wire

// ---- rtl/sign_test_branch_decode.v ----
/*
 * Decoder and sequencer for the four branches that test whether a general
 * register is non-negative, with and without link, plain and likely.
 * Assumes fetch presents one instruction per inst_valid with its address
 * and the full value of the register named in its tested field, all
 * synchronous to ref_clk; the core applies the link write, the slot kill
 * and the resolution outputs one cycle after the instruction is taken.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sign_branch_regs.vh"

// How it works
// RL1: decode opcode one, selectors one and three
// RL2: link selectors seventeen and nineteen, same opcode
// RL3: target is slot address plus offset times four
// RL4: taken when tested register sign bit clear
// RL5: delay slot runs first, then redirect
// RL6: likely not taken kills the delay slot
// RL7: link variants write r31 with branch+8 always
// RL8: software never tests r31 in link forms
// RL9: software puts no control transfer in slot
// RL10: link on zero register is unconditional call
// RL11: software should avoid the likely forms
// RL12: not taken falls through, never raises exceptions
module sign_test_branch_decode #(
    parameter DATA_W = 32                   // width of a general register
) (
    input  wire              ref_clk,         // core clock
    input  wire              rstn,            // async reset, active low
    input  wire              inst_valid,      // instruction presented this cycle
    input  wire [31:0]       inst_word,       // instruction word
    input  wire [31:0]       inst_pc,         // address of that instruction
    input  wire [DATA_W-1:0] tested_value,    // value of the tested register
    input  wire              slot_flush,      // core abandons pending branch
    output reg               branch_hit_q,    // pulse: branch recognised
    output reg               is_likely_q,     // recognised branch is likely form
    output reg               is_link_q,       // recognised branch links
    output reg               cond_q,          // condition of recognised branch
    output reg               link_we_q,       // pulse: write return link
    output reg  [4:0]        link_addr_q,     // link destination register
    output reg  [31:0]       link_data_q,     // return link value
    output reg               wait_slot_q,     // waiting for delay slot
    output reg               slot_run_q,      // pulse: delay slot executes
    output reg               slot_kill_q,     // pulse: delay slot nullified
    output reg               resolve_q,       // pulse: next fetch address known
    output reg               resolve_taken_q, // resolved as taken
    output reg  [31:0]       resolve_pc_q,    // next fetch address
    output reg               fault_q          // never set: no exceptions
);

    localparam ST_IDLE      = `ST_IDLE;
    localparam ST_WAIT_SLOT = `ST_WAIT_SLOT;

    wire [5:0]  opc_field;
    wire [4:0]  tst_field;
    wire [4:0]  sel_field;
    wire [15:0] off_field;
    wire [31:0] slot_pc;
    wire [31:0] target_pc;
    wire [31:0] link_pc;

    reg         dec_hit;
    reg         dec_likely;
    reg         dec_link;
    reg         dec_cond;

    reg         state_q;
    reg         state_d;
    reg         pend_taken_q;
    reg         pend_taken_d;
    reg         pend_likely_q;
    reg         pend_likely_d;
    reg  [31:0] pend_target_q;
    reg  [31:0] pend_target_d;
    reg  [31:0] pend_fall_q;
    reg  [31:0] pend_fall_d;

    assign opc_field = inst_word[`OPC_MSB:`OPC_LSB];
    assign tst_field = inst_word[`TST_MSB:`TST_LSB];
    assign sel_field = inst_word[`SEL_MSB:`SEL_LSB];
    assign off_field = inst_word[`OFF_MSB:`OFF_LSB];

    branch_target_calc u_target (
        .branch_pc (inst_pc),
        .offset    (off_field),
        .slot_pc   (slot_pc),
        .target_pc (target_pc),
        .link_pc   (link_pc)
    );

    // decode of the four forms
    always @* begin
        dec_hit    = 1'b0;
        dec_likely = 1'b0;
        dec_link   = 1'b0;
        if (opc_field == `OPC_REG_IMM) begin
            case (sel_field)
                `SEL_PLAIN: begin
                    dec_hit = 1'b1; // RL1
                end
                `SEL_LIKELY: begin
                    dec_hit    = 1'b1; // RL1
                    dec_likely = 1'b1;
                end
                `SEL_LINK: begin
                    dec_hit  = 1'b1; // RL2
                    dec_link = 1'b1;
                end
                `SEL_LINK_LIKELY: begin
                    dec_hit    = 1'b1; // RL2
                    dec_likely = 1'b1;
                    dec_link   = 1'b1;
                end
                default: begin
                    dec_hit = 1'b0;
                end
            endcase
        end
    end

    // the zero register reads as zero whatever the port carries
    always @* begin
        if (tst_field == `ZERO_REG) begin
            dec_cond = 1'b1; // RL10
        end else begin
            dec_cond = ~tested_value[DATA_W-1]; // RL4
        end
    end

    // branch waits in ST_WAIT_SLOT; the slot itself is never decoded
    always @* begin
        state_d       = state_q;
        pend_taken_d  = pend_taken_q;
        pend_likely_d = pend_likely_q;
        pend_target_d = pend_target_q;
        pend_fall_d   = pend_fall_q;
        case (state_q)
            ST_IDLE: begin
                if (inst_valid && dec_hit) begin
                    state_d       = ST_WAIT_SLOT; // RL5
                    pend_taken_d  = dec_cond;
                    pend_likely_d = dec_likely;
                    pend_target_d = target_pc;
                    pend_fall_d   = link_pc; // RL12
                end
            end
            ST_WAIT_SLOT: begin
                // a control transfer in the slot is not looked at here RL9
                if (slot_flush || inst_valid) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= ST_IDLE;
            pend_taken_q  <= 1'b0;
            pend_likely_q <= 1'b0;
            pend_target_q <= 32'h0000_0000;
            pend_fall_q   <= 32'h0000_0000;
        end else begin
            state_q       <= state_d;
            pend_taken_q  <= pend_taken_d;
            pend_likely_q <= pend_likely_d;
            pend_target_q <= pend_target_d;
            pend_fall_q   <= pend_fall_d;
        end
    end

    // decode report and link write, one cycle after the branch
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            branch_hit_q <= 1'b0;
            is_likely_q  <= 1'b0;
            is_link_q    <= 1'b0;
            cond_q       <= 1'b0;
            link_we_q    <= 1'b0;
            link_addr_q  <= `LINK_REG;
            link_data_q  <= 32'h0000_0000;
            wait_slot_q  <= 1'b0;
        end else begin
            branch_hit_q <= 1'b0;
            link_we_q    <= 1'b0;
            wait_slot_q  <= state_d;
            if (state_q == ST_IDLE && inst_valid && dec_hit) begin
                branch_hit_q <= 1'b1;
                is_likely_q  <= dec_likely;
                is_link_q    <= dec_link;
                cond_q       <= dec_cond;
                // written taken or not; condition was sampled first RL8
                link_we_q    <= dec_link; // RL7
                link_data_q  <= link_pc; // RL7
            end
        end
    end

    // resolution when the delay slot arrives
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slot_run_q      <= 1'b0;
            slot_kill_q     <= 1'b0;
            resolve_q       <= 1'b0;
            resolve_taken_q <= 1'b0;
            resolve_pc_q    <= 32'h0000_0000;
            fault_q         <= 1'b0;
        end else begin
            slot_run_q  <= 1'b0;
            slot_kill_q <= 1'b0;
            resolve_q   <= 1'b0;
            fault_q     <= 1'b0; // RL12
            if (state_q == ST_WAIT_SLOT && !slot_flush && inst_valid) begin
                resolve_q       <= 1'b1; // RL5
                resolve_taken_q <= pend_taken_q;
                if (pend_taken_q) begin
                    slot_run_q   <= 1'b1; // RL5
                    resolve_pc_q <= pend_target_q; // RL3
                end else begin
                    slot_run_q   <= ~pend_likely_q;
                    slot_kill_q  <= pend_likely_q; // RL6
                    resolve_pc_q <= pend_fall_q; // RL12
                end
            end
        end
    end

endmodule // sign_test_branch_decode

`default_nettype wire
